/* hdl/tpwm_top.sv */
// Three-phase center-based PWM unit with APB registers and interrupt
// Behaviour
// RQ1: 16-bit counter runs up then down
// RQ2: six outputs, high and low per phase
// RQ3: software picks active-high or active-low outputs
// RQ4: period register sets switching frequency
// RQ5: single update loads duties at period start
// RQ6: double update also reloads at midpoint
// RQ7: internal sync pulse driven on sync pin
// RQ8: external sync pulse on pin restarts counter
// RQ9: shutdown low forces outputs off asynchronously; the code clears them to 0, which is the active level when active-low
// RQ10: programmable dead time between complementary edges
// RQ11: duties are two's complement, saturate full
// RQ12: crossover and per-output enables for brushless
// RQ13: switched reluctance modes selectable by software
// RQ14: run bit gates the generator clock
// RQ15: output active inside duty interval around midpoint
// RQ16: shutdown holds until software clears it
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.svh"

module tpwm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwm_shutdown_n,
    input wire logic pwm_sync_pin_i,
    output logic pwm_sync_pin_o,
    output logic pwm_sync_pin_oe_n,
    output logic phase_a_high_out,
    output logic phase_b_high_out,
    output logic phase_c_high_out,
    output logic phase_a_low_out,
    output logic phase_b_low_out,
    output logic phase_c_low_out,
    output logic irq
);

    tpwm_pkg::tpwm_top_st_t q;
    tpwm_pkg::tpwm_top_st_t d;

    // Counter and phase wiring
    logic [15:0] count;
    logic start_p;
    logic mid_p;
    logic restart;
    logic phase_arst_n;
    logic [2:0] hi_w;
    logic [2:0] lo_w;
    tpwm_pkg::tpwm_drv_t [2:0] drv;

    // Bus decode helpers
    logic access;
    logic wr;
    logic hit;
    logic [31:0] rdata;
    logic [1:0] st_clr;
    logic [1:0] st_set;

    // External sync edge, taken from the second synchroniser stage
    assign restart = q.ctrl.ext_sync & q.sync_s2 & ~q.sync_s3; // RQ8

    // Shutdown pin acts on the output flops with no clock
    // The gated reset is the price of a truly asynchronous trip
    assign phase_arst_n = presetn & pwm_shutdown_n; // RQ9

    // Period counter
    tpwm_counter u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .run(q.ctrl.run),
        .restart(restart),
        .period(q.period),
        .count(count),
        .start_p(start_p),
        .mid_p(mid_p)
    );

    // One phase engine per leg
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_phase
            // Held shutdown masks both sides so polarity sets the OFF level
            always_comb begin
                drv[gi].pol_low = q.ctrl.pol_low;
                drv[gi].xover = q.ctrl.xover;
                drv[gi].sr_mode = q.ctrl.sr_mode;
                drv[gi].en_hi = q.outen[gi] & ~q.trip_hold; // RQ16
                drv[gi].en_lo = q.outen[gi + 3] & ~q.trip_hold; // RQ16
            end

            tpwm_phase u_ph (
                .pclk(pclk),
                .arst_n(phase_arst_n),
                .count(count),
                .period(q.period),
                .duty(q.duty_act[gi]),
                .dead(q.dead),
                .drv(drv[gi]),
                .hi_out(hi_w[gi]),
                .lo_out(lo_w[gi])
            );
        end
    endgenerate

    // APB access phase lasts two cycles, pready from a flop
    // Writes land on the completing edge, where the master sees pready
    always_comb begin
        access = psel & penable & ~q.pready;
        wr = psel & penable & q.pready & pwrite;
    end

    // Read mux and address hit
    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            `TPWM_OFF_CTRL: rdata = {25'h0000000, q.ctrl};
            `TPWM_OFF_PERIOD: rdata = {16'h0000, q.period};
            `TPWM_OFF_DUTY_A: rdata = {16'h0000, q.duty_sh[0]};
            `TPWM_OFF_DUTY_B: rdata = {16'h0000, q.duty_sh[1]};
            `TPWM_OFF_DUTY_C: rdata = {16'h0000, q.duty_sh[2]};
            `TPWM_OFF_DEAD: rdata = {16'h0000, q.dead};
            `TPWM_OFF_OUTEN: rdata = {26'h0000000, q.outen};
            `TPWM_OFF_STATUS: rdata = {29'h00000000, q.trip_hold, q.status};
            `TPWM_OFF_IMASK: rdata = {30'h00000000, q.imask};
            `TPWM_OFF_COUNT: rdata = {16'h0000, count};
            default: hit = 1'b0;
        endcase
    end

    // Sticky events: trip while pin low, sync at each period start
    always_comb begin
        st_set = 2'b00;
        st_set[`TPWM_ST_TRIP] = ~q.shut_s2;
        st_set[`TPWM_ST_SYNC] = start_p;
        st_clr = 2'b00;
        if (wr && hit && paddr == `TPWM_OFF_STATUS) begin
            st_clr = pwdata[1:0];
        end
    end

    // Next state
    always_comb begin
        d = q;

        // Two-flop synchronisers for the pins
        d.shut_s1 = pwm_shutdown_n;
        d.shut_s2 = q.shut_s1;
        d.sync_s1 = pwm_sync_pin_i;
        d.sync_s2 = q.sync_s1;
        d.sync_s3 = q.sync_s2;

        // Register writes
        if (wr && hit) begin
            case (paddr)
                `TPWM_OFF_CTRL: d.ctrl = tpwm_pkg::tpwm_ctrl_t'(pwdata[`TPWM_CTRL_W-1:0]);
                `TPWM_OFF_PERIOD: d.period = pwdata[15:0]; // RQ4
                `TPWM_OFF_DUTY_A: d.duty_sh[0] = pwdata[15:0];
                `TPWM_OFF_DUTY_B: d.duty_sh[1] = pwdata[15:0];
                `TPWM_OFF_DUTY_C: d.duty_sh[2] = pwdata[15:0];
                `TPWM_OFF_DEAD: d.dead = pwdata[15:0]; // RQ10
                `TPWM_OFF_OUTEN: d.outen = pwdata[5:0]; // RQ12
                `TPWM_OFF_IMASK: d.imask = pwdata[1:0];
                default: d.imask = q.imask;
            endcase
        end

        // Shadow duties reach the compare only at update points
        // Stopped generator loads at once so software can preset
        if (!q.ctrl.run || start_p) begin
            d.duty_act = q.duty_sh; // RQ5
        end else if (mid_p && q.ctrl.dbl) begin
            d.duty_act = q.duty_sh; // RQ6
        end

        // Status: a set in the clearing cycle wins
        d.status = (q.status & ~st_clr) | st_set;

        // Latched trip released by writing one once the pin is high
        if (!q.shut_s2) begin
            d.trip_hold = 1'b1; // RQ16
        end else if (st_clr[`TPWM_ST_TRIP]) begin
            d.trip_hold = 1'b0; // RQ16
        end

        // Sync pin: drive period-start pulse unless following outside
        d.sync_oe_n = q.ctrl.ext_sync; // RQ8
        d.sync_o = start_p & ~q.ctrl.ext_sync; // RQ7

        // Level interrupt from unmasked sticky bits
        d.irq = |(d.status & q.imask);

        // Bus answer
        d.pready = access;
        d.pslverr = access & ~hit;
        if (access && !pwrite) begin
            d.prdata = rdata;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.ctrl <= tpwm_pkg::tpwm_ctrl_t'(`TPWM_CTRL_RST);
            q.period <= `TPWM_PERIOD_RST;
            q.duty_sh <= {3{`TPWM_DUTY_RST}};
            q.duty_act <= {3{`TPWM_DUTY_RST}};
            q.dead <= `TPWM_DEAD_RST;
            q.outen <= `TPWM_OUTEN_RST;
            q.imask <= `TPWM_MASK_RST;
            q.shut_s1 <= 1'b1;
            q.shut_s2 <= 1'b1;
            q.sync_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs, each straight from a flop
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign pwm_sync_pin_o = q.sync_o;
    assign pwm_sync_pin_oe_n = q.sync_oe_n;
    assign phase_a_high_out = hi_w[0]; // RQ2
    assign phase_b_high_out = hi_w[1];
    assign phase_c_high_out = hi_w[2];
    assign phase_a_low_out = lo_w[0];
    assign phase_b_low_out = lo_w[1];
    assign phase_c_low_out = lo_w[2];

endmodule : tpwm_top
`default_nettype wire

/* hdl/tpwm_regs.svh */
// Register offsets, field positions, reset values and widths of the three-phase PWM unit
`ifndef TPWM_REGS_SVH
`define TPWM_REGS_SVH

// Byte offsets on the APB bus
`define TPWM_OFF_CTRL 8'h00
`define TPWM_OFF_PERIOD 8'h04
`define TPWM_OFF_DUTY_A 8'h08
`define TPWM_OFF_DUTY_B 8'h0C
`define TPWM_OFF_DUTY_C 8'h10
`define TPWM_OFF_DEAD 8'h14
`define TPWM_OFF_OUTEN 8'h18
`define TPWM_OFF_STATUS 8'h1C
`define TPWM_OFF_IMASK 8'h20
`define TPWM_OFF_COUNT 8'h24

// Control field positions
`define TPWM_CTRL_RUN 0
`define TPWM_CTRL_DBL 1
`define TPWM_CTRL_EXT 2
`define TPWM_CTRL_POL 3
`define TPWM_CTRL_XOVER 4
`define TPWM_CTRL_SR_LO 5
`define TPWM_CTRL_W 7

// Status and mask field positions
`define TPWM_ST_TRIP 0
`define TPWM_ST_SYNC 1
`define TPWM_ST_HOLD 2
`define TPWM_ST_W 2

// Reset values
`define TPWM_CTRL_RST 7'h00
`define TPWM_PERIOD_RST 16'h0100
`define TPWM_DUTY_RST 16'h0000
`define TPWM_DEAD_RST 16'h0004
`define TPWM_OUTEN_RST 6'h3F
`define TPWM_MASK_RST 2'h0

// Widths
`define TPWM_CNT_W 16
`define TPWM_DCNT_MAX 16'hFFFF

`endif

/* hdl/tpwm_pkg.sv */
// Types shared by the three-phase PWM unit
`default_nettype none
package tpwm_pkg;

    // Counter direction of the triangle
    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } tpwm_dir_t;

    // Switched reluctance output modes
    typedef enum logic [1:0] {
        SR_OFF = 2'b00,
        SR_LOW_ON = 2'b01,
        SR_PAIR = 2'b10,
        SR_HIGH_ON = 2'b11
    } tpwm_sr_t;

    // Control register layout
    typedef struct packed {
        tpwm_sr_t sr_mode;
        logic xover;
        logic pol_low;
        logic ext_sync;
        logic dbl;
        logic run;
    } tpwm_ctrl_t;

    // Per-phase drive settings
    typedef struct packed {
        logic pol_low;
        logic xover;
        tpwm_sr_t sr_mode;
        logic en_hi;
        logic en_lo;
    } tpwm_drv_t;

    // Counter state
    typedef struct packed {
        tpwm_dir_t dir;
        logic [15:0] cnt;
        logic start;
        logic mid;
    } tpwm_cnt_st_t;

    // Phase state
    typedef struct packed {
        logic raw;
        logic [15:0] dtc;
        logic hi;
        logic lo;
    } tpwm_ph_st_t;

    // Top state
    typedef struct packed {
        tpwm_ctrl_t ctrl;
        logic [15:0] period;
        logic [2:0][15:0] duty_sh;
        logic [2:0][15:0] duty_act;
        logic [15:0] dead;
        logic [5:0] outen;
        logic [1:0] status;
        logic [1:0] imask;
        logic trip_hold;
        logic shut_s1;
        logic shut_s2;
        logic sync_s1;
        logic sync_s2;
        logic sync_s3;
        logic sync_o;
        logic sync_oe_n;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tpwm_top_st_t;

endpackage : tpwm_pkg
`default_nettype wire

/* hdl/tpwm_counter.sv */
// Center-based up/down period counter with start and midpoint pulses
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.svh"

module tpwm_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic restart,
    input wire logic [15:0] period,
    output logic [15:0] count,
    output logic start_p,
    output logic mid_p
);

    tpwm_pkg::tpwm_cnt_st_t q;
    tpwm_pkg::tpwm_cnt_st_t d;

    // Triangle: up from zero to the period, then back down
    always_comb begin
        d = q;
        d.start = 1'b0;
        d.mid = 1'b0;
        if (restart) begin
            d.cnt = 16'h0000; // RQ8
            d.dir = tpwm_pkg::DIR_UP;
            d.start = 1'b1;
        end else if (run) begin // RQ14
            case (q.dir)
                tpwm_pkg::DIR_UP: begin
                    if (q.cnt >= period) begin // RQ4
                        d.mid = 1'b1; // RQ6
                        // Zero period would wrap below zero, so it idles
                        if (period == 16'h0000) begin
                            d.start = 1'b1;
                        end else begin
                            d.dir = tpwm_pkg::DIR_DOWN;
                            d.cnt = q.cnt - 16'h0001;
                        end
                    end else begin
                        d.cnt = q.cnt + 16'h0001; // RQ1
                    end
                end
                tpwm_pkg::DIR_DOWN: begin
                    if (q.cnt <= 16'h0001) begin
                        d.dir = tpwm_pkg::DIR_UP;
                        d.cnt = 16'h0000;
                        d.start = 1'b1; // RQ5
                    end else begin
                        d.cnt = q.cnt - 16'h0001;
                    end
                end
                default: begin
                    d.dir = tpwm_pkg::DIR_UP;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign start_p = q.start;
    assign mid_p = q.mid;

endmodule : tpwm_counter
`default_nettype wire

/* hdl/tpwm_phase.sv */
// One phase: duty compare, dead time, mode shaping and output flops
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.svh"

module tpwm_phase (
    input wire logic pclk,
    input wire logic arst_n,
    input wire logic [15:0] count,
    input wire logic [15:0] period,
    input wire logic [15:0] duty,
    input wire logic [15:0] dead,
    input wire tpwm_pkg::tpwm_drv_t drv,
    output logic hi_out,
    output logic lo_out
);

    tpwm_pkg::tpwm_ph_st_t q;
    tpwm_pkg::tpwm_ph_st_t d;
    logic signed [17:0] thresh;
    logic act;
    logic settled;
    logic h;
    logic l;

    // Pulse of width twice the duty plus one count, centred on the count peak
    // Signed duty: below zero is full OFF, period or above full ON
    always_comb begin
        thresh = $signed({2'b00, period}) - $signed({{2{duty[15]}}, duty}); // RQ11
        act = $signed({2'b00, count}) >= thresh; // RQ15
    end

    // Dead time, crossover, reluctance modes, enables, polarity
    always_comb begin
        d = q;
        d.raw = act;
        if (act != q.raw) begin
            d.dtc = 16'h0000; // RQ10
        end else if (q.dtc != `TPWM_DCNT_MAX) begin
            d.dtc = q.dtc + 16'h0001;
        end
        settled = (act == q.raw) && (q.dtc >= dead); // RQ10
        h = act & settled;
        l = ~act & settled;
        if (drv.xover) begin
            h = ~act & settled; // RQ12
            l = act & settled;
        end
        case (drv.sr_mode)
            tpwm_pkg::SR_LOW_ON: l = 1'b1; // RQ13
            tpwm_pkg::SR_PAIR: l = h; // RQ13
            tpwm_pkg::SR_HIGH_ON: h = 1'b1; // RQ13
            default: h = h;
        endcase
        h = h & drv.en_hi; // RQ12
        l = l & drv.en_lo; // RQ12
        d.hi = h ^ drv.pol_low; // RQ3
        d.lo = l ^ drv.pol_low; // RQ3
    end

    // Cleared at once by reset or by the shutdown pin, no clock needed
    always_ff @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0; // RQ9
        end else begin
            q <= d;
        end
    end

    assign hi_out = q.hi;
    assign lo_out = q.lo;

endmodule : tpwm_phase
`default_nettype wire

/* test/tpwm_top_sva.sv */
// Port-level assertions for the three-phase PWM unit
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.svh"

module tpwm_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwm_shutdown_n,
    input wire logic pwm_sync_pin_o,
    input wire logic pwm_sync_pin_oe_n,
    input wire logic phase_a_high_out,
    input wire logic phase_b_high_out,
    input wire logic phase_c_high_out,
    input wire logic phase_a_low_out,
    input wire logic phase_b_low_out,
    input wire logic phase_c_low_out,
    input wire logic irq
);
    logic wr;
    logic [5:0] ph;
    logic [6:0] ctrl_q;
    logic [2:0] quiet_q;

    // Accepted write and the six drives as one vector
    assign wr = psel && penable && pready && pwrite;
    assign ph = {phase_a_high_out, phase_b_high_out, phase_c_high_out,
        phase_a_low_out, phase_b_low_out, phase_c_low_out};

    // Snooped control; quiet count skips the cycles a mode change needs to settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 7'h00;
            quiet_q <= 3'h0;
        end else if (wr && paddr == `TPWM_OFF_CTRL) begin
            ctrl_q <= pwdata[6:0];
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pready_one_a: assert property (pready |=> !pready) else $error("pready too long");
    apb_wait_a: assert property (psel && !penable ##1 psel && penable |=> pready) else $error("pready late");
    err_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    map_err_a: assert property (psel && penable && pready |-> pslverr == (paddr > `TPWM_OFF_COUNT))
        else $error("pslverr wrong for address");
    trip_off_a: assert property (!pwm_shutdown_n |-> ph == 6'h00) else $error("drive on during trip");
    dead_gap_a: assert property (quiet_q == 3'h7 && ctrl_q[6:3] == 4'h0 |-> (ph[5:3] & ph[2:0]) == 3'h0)
        else $error("high and low both active");
    dead_edge_a: assert property (quiet_q == 3'h7 && ctrl_q[6:3] == 4'h0 && phase_a_high_out |=> !phase_a_low_out)
        else $error("no dead gap after high side");
    sync_pulse_a: assert property (pwm_sync_pin_o |-> !pwm_sync_pin_oe_n ##1 !pwm_sync_pin_o)
        else $error("sync pulse wrong");
    sync_dir_a: assert property (wr && paddr == `TPWM_OFF_CTRL |-> ##2 pwm_sync_pin_oe_n == ctrl_q[2])
        else $error("sync pin direction wrong");
    irq_mask_a: assert property (wr && paddr == `TPWM_OFF_IMASK && pwdata[1:0] == 2'h0 |-> ##2 !irq)
        else $error("irq with mask clear");

    cover property (!pwm_shutdown_n ##1 pwm_shutdown_n);
    cover property (irq);
    cover property (pslverr);
    cover property (pwm_sync_pin_oe_n && quiet_q == 3'h7);
endmodule : tpwm_top_sva

bind tpwm_top tpwm_top_sva tpwm_top_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .pwm_shutdown_n, .pwm_sync_pin_o, .pwm_sync_pin_oe_n, .phase_a_high_out,
    .phase_b_high_out, .phase_c_high_out, .phase_a_low_out, .phase_b_low_out, .phase_c_low_out, .irq);
`default_nettype wire

/* test/tpwm_sync_model.sv */
// Outside sync source and sync pin resolution
`timescale 1ns/1ps
`default_nettype none

module tpwm_sync_model (
    input wire logic pclk,
    input wire logic pulse_req,
    input wire logic sync_o,
    input wire logic sync_oe_n,
    output logic sync_i
);
    logic drive_q;

    // Source changes its level just after an edge, like a real clocked driver
    always_ff @(posedge pclk) begin
        drive_q <= pulse_req;
    end

    // Unit drives while oe_n low; otherwise the pulled-down line carries the source pulse
    assign sync_i = !sync_oe_n ? sync_o : drive_q;
endmodule : tpwm_sync_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench of the three-phase PWM unit
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_regs.svh"

module tb_top;
    typedef struct packed {logic [7:0] c; logic [7:0] o; logic [3:0] m; logic [3:0] x;} tpwm_mode_t;
    typedef struct packed {logic [7:0] a; logic [31:0] v;} tpwm_rst_t;
    logic pclk, pready, pslverr, sync_i, sync_o, sync_oe_n, irq, e;
    logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pwm_shutdown_n = 1'b1, ext_pulse = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    wire logic [5:0] ph;
    int n_mismatch = 0, cmp_count = 0, m, m1;
    int cnt [6];
    // Ctrl, outen, mask, expected {b_h, c_h, b_l, c_l}; B never active, C always
    tpwm_mode_t modes [7] = '{'{8'h01, 8'h3F, 4'hF, 4'h6}, '{8'h09, 8'h3F, 4'hF, 4'h9},
        '{8'h11, 8'h3F, 4'hF, 4'h9}, '{8'h01, 8'h3B, 4'hF, 4'h2}, '{8'h21, 8'h3F, 4'h3, 4'h3},
        '{8'h41, 8'h3F, 4'hF, 4'h5}, '{8'h61, 8'h3F, 4'hC, 4'hC}};
    tpwm_rst_t rsts [9] = '{'{8'h00, 32'h0}, '{8'h04, 32'h100}, '{8'h08, 32'h0}, '{8'h10, 32'h0},
        '{8'h14, 32'h4}, '{8'h18, 32'h3F}, '{8'h1C, 32'h0}, '{8'h20, 32'h0}, '{8'h40, 32'h0}};

    tpwm_top tpwm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_shutdown_n(pwm_shutdown_n), .pwm_sync_pin_i(sync_i), .pwm_sync_pin_o(sync_o),
        .pwm_sync_pin_oe_n(sync_oe_n), .phase_a_high_out(ph[5]), .phase_b_high_out(ph[4]),
        .phase_c_high_out(ph[3]), .phase_a_low_out(ph[2]), .phase_b_low_out(ph[1]),
        .phase_c_low_out(ph[0]), .irq(irq));
    tpwm_sync_model tpwm_sync_model_i (.pclk(pclk), .pulse_req(ext_pulse), .sync_o(sync_o),
        .sync_oe_n(sync_oe_n), .sync_i(sync_i));

    // 100 ns clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic results;
        $display("TB: %0d compares, %0d mismatches", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                results();
            end
            @(posedge pclk);
        end
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Waits end mid-cycle, where outputs are settled
    task automatic cyc(input int k);
        repeat (k) @(negedge pclk);
    endtask : cyc

    task automatic meas(input int k);
        cnt = '{default: 0};
        repeat (k) begin
            @(negedge pclk);
            foreach (cnt[i]) cnt[i] += ph[i];
        end
    endtask : meas

    // Cycles up to the next internal sync pulse, bounded
    task automatic wait_sync;
        m = 1;
        @(negedge pclk);
        while (sync_o !== 1'b1) begin
            m++;
            if (m > 200) begin
                n_mismatch++;
                results();
            end
            @(negedge pclk);
        end
    endtask : wait_sync

    // Main sequence: period 8, dead 1, duties A mid, B negative, C full
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `TPWM_OFF_PERIOD, 32'h8);
        apb(1'b1, `TPWM_OFF_DEAD, 32'h1);
        apb(1'b1, `TPWM_OFF_DUTY_A, 32'h4);
        apb(1'b1, `TPWM_OFF_DUTY_B, 32'hFFF0);
        apb(1'b1, `TPWM_OFF_DUTY_C, 32'h8);
        foreach (modes[i]) begin
            apb(1'b1, `TPWM_OFF_CTRL, {24'h0, modes[i].c});
            apb(1'b1, `TPWM_OFF_OUTEN, {24'h0, modes[i].o});
            cyc(40);
            check({ph[4:3], ph[1:0]} & modes[i].m, modes[i].x);
        end
        $display("TB: mode table done");
        apb(1'b1, `TPWM_OFF_CTRL, 32'h1);
        cyc(40);
        meas(16);
        check(cnt[4] + cnt[0], 0);
        check(cnt[5] > 0 && cnt[5] + cnt[2] < 16, 1);
        apb(1'b0, `TPWM_OFF_COUNT, 32'h0);
        check(v <= 32'h8, 1);
        wait_sync();
        wait_sync();
        check(m, 16);
        // Duty dropped just after start: only double update reloads it at midpoint
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, `TPWM_OFF_CTRL, d ? 32'h3 : 32'h1);
            wait_sync();
            apb(1'b1, `TPWM_OFF_DUTY_A, 32'h0);
            meas(12);
            m1 = d ? m1 - cnt[5] : cnt[5];
            apb(1'b1, `TPWM_OFF_DUTY_A, 32'h4);
        end
        check(m1 > 0, 1);
        $display("TB: duty and update done");
        // Outside pulses every 4 cycles keep the count below duty A's threshold
        apb(1'b1, `TPWM_OFF_CTRL, 32'h5);
        cyc(2);
        check(sync_oe_n, 1);
        fork
            repeat (12) begin
                @(posedge pclk);
                ext_pulse <= 1'b1;
                repeat (2) @(posedge pclk);
                ext_pulse <= 1'b0;
                @(posedge pclk);
            end
            begin
                cyc(16);
                meas(24);
            end
        join
        check(cnt[5], 0);
        apb(1'b1, `TPWM_OFF_CTRL, 32'h1);
        $display("TB: sync done");
        // Trip: async off, sticky hold, interrupt masked and cleared
        apb(1'b1, `TPWM_OFF_IMASK, 32'h1);
        @(posedge pclk);
        pwm_shutdown_n <= 1'b0;
        #10;
        check(ph, 0);
        cyc(6);
        check(irq, 1);
        @(posedge pclk);
        pwm_shutdown_n <= 1'b1;
        cyc(10);
        check(ph[3], 0);
        apb(1'b0, `TPWM_OFF_STATUS, 32'h0);
        check(v[0], 1);
        apb(1'b1, `TPWM_OFF_IMASK, 32'h0);
        cyc(2);
        check(irq, 0);
        apb(1'b1, `TPWM_OFF_IMASK, 32'h1);
        cyc(2);
        check(irq, 1);
        apb(1'b1, `TPWM_OFF_STATUS, 32'h1);
        cyc(40);
        check({irq, ph[3]}, 2'h1);
        apb(1'b1, 8'h40, 32'h1);
        check(e, 1);
        apb(1'b1, `TPWM_OFF_COUNT, 32'hFFFF);
        check(e, 0);
        $display("TB: trip and bus done");
        // Second reset in mid-run, then reset values
        @(posedge pclk);
        presetn <= 1'b0;
        cyc(3);
        check({ph, sync_oe_n}, 7'h01);
        @(posedge pclk);
        presetn <= 1'b1;
        foreach (rsts[i]) begin
            apb(1'b0, rsts[i].a, 32'h0);
            check(v, rsts[i].v);
            check(e, rsts[i].a > 8'h24);
        end
        $display("TB: reset values done");
        results();
    end
endmodule : tb_top
`default_nettype wire
